//--- rtl/sts3_rx_frame_sync_fsm.sv
`timescale 1ns/1ps
module sts3_rx_frame_sync_fsm (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Line side, same clock domain
  input wire logic frame_start_i,
  input wire logic byte_valid_i,
  input wire logic [7:0] rx_byte_i,
  // AXI4-Lite write address
  input wire logic awvalid_i,
  output logic awready_o,
  input wire logic [15:0] awaddr_i,
  // AXI4-Lite write data
  input wire logic wvalid_i,
  output logic wready_o,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] wstrb_i,
  // AXI4-Lite write response
  output logic bvalid_o,
  input wire logic bready_i,
  output logic [1:0] bresp_o,
  // AXI4-Lite read address
  input wire logic arvalid_i,
  output logic arready_o,
  input wire logic [15:0] araddr_i,
  // AXI4-Lite read data
  output logic rvalid_o,
  input wire logic rready_i,
  output logic [31:0] rdata_o,
  output logic [1:0] rresp_o,
  // Interrupt and defect status pins
  output logic irq_n_o,
  output logic sef_o,
  output logic lof_o
);
  typedef struct packed {
    frame_sync_pkg::sync_state_t state;
    logic [3:0] err_cnt;
    logic [3:0] ok_cnt;
    logic [5:0] sef_frames;
    logic [1:0] fpos;
    logic cur_err;
    logic [7:0] status;
    logic [7:0] events;
    logic [7:0] mask;
    logic [3:0] insync;
    logic [15:0] aw_addr;
    logic aw_have;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic w_have;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic irq_n;
  } state_t;

  state_t q_r, q_nxt;
  logic [1:0] rst_sync_r;
  logic rst_n;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // Offsets are word indexes: the byte address is four times the index
  function automatic logic addr_is(input logic [15:0] a, input logic [15:0] ofs);
    addr_is = (a[15:2] == ofs[13:0]);
  endfunction

  function automatic logic [3:0] sat_inc(input logic [3:0] v);
    sat_inc = (v == 4'hf) ? v : v + 4'h1;
  endfunction

  logic frame_end;
  logic frame_err;
  logic [3:0] err_n;
  logic [3:0] ok_n;
  logic [7:0] set_ev;
  logic aw_go;
  logic ar_go;
  logic [15:0] wa;
  logic [31:0] wd;
  logic [3:0] ws;
  logic [3:0] clean_need;

  always_comb begin
    q_nxt = q_r;
    set_ev = 8'h00;
    frame_end = 1'b0;
    frame_err = 1'b0;
    // Framing check of first A1 and A2 bytes after frame start
    if (frame_start_i) begin
      q_nxt.fpos = 2'h1;
      q_nxt.cur_err = 1'b0;
    end else if (byte_valid_i && q_r.fpos != 2'h0) begin
      if (q_r.fpos == 2'h1) begin
        q_nxt.cur_err = (rx_byte_i != frame_sync_pkg::FRAMING_A1);
        q_nxt.fpos = 2'h2;
      end else if (q_r.fpos == 2'h2) begin
        frame_end = 1'b1;
        frame_err = q_r.cur_err | (rx_byte_i != frame_sync_pkg::FRAMING_A2);
        q_nxt.fpos = 2'h0;
      end
    end
    err_n = frame_err ? sat_inc(q_r.err_cnt) : 4'h0;
    ok_n = frame_err ? 4'h0 : sat_inc(q_r.ok_cnt);
    // A threshold of zero still needs one clean frame to leave
    clean_need = (q_r.insync == 4'h0) ? 4'h1 : q_r.insync;
    if (frame_end) begin
      q_nxt.err_cnt = err_n;
      q_nxt.ok_cnt = ok_n;
      unique case (q_r.state)
        frame_sync_pkg::ST_SEF1_LOF1: begin
          if (ok_n >= frame_sync_pkg::CLEAN_CLEAR) begin
            q_nxt.state = frame_sync_pkg::ST_SEF0_LOF1;
            q_nxt.status[frame_sync_pkg::BIT_SEF] = 1'b0;
            set_ev[frame_sync_pkg::BIT_SEF] = 1'b1;
            q_nxt.ok_cnt = 4'h0;
            q_nxt.err_cnt = 4'h0;
          end
        end
        frame_sync_pkg::ST_SEF0_LOF1: begin
          if (err_n >= frame_sync_pkg::ERR_DECLARE) begin
            q_nxt.state = frame_sync_pkg::ST_SEF1_LOF1;
            q_nxt.status[frame_sync_pkg::BIT_SEF] = 1'b1;
            set_ev[frame_sync_pkg::BIT_SEF] = 1'b1;
            q_nxt.ok_cnt = 4'h0;
            q_nxt.err_cnt = 4'h0;
          end else if (ok_n >= clean_need) begin
            q_nxt.state = frame_sync_pkg::ST_IN_FRAME;
            q_nxt.status[frame_sync_pkg::BIT_LOF] = 1'b0;
            set_ev[frame_sync_pkg::BIT_LOF] = 1'b1;
            q_nxt.ok_cnt = 4'h0;
            q_nxt.err_cnt = 4'h0;
          end
        end
        frame_sync_pkg::ST_IN_FRAME: begin
          if (err_n >= frame_sync_pkg::ERR_DECLARE) begin
            q_nxt.state = frame_sync_pkg::ST_SEF1_LOF0;
            q_nxt.status[frame_sync_pkg::BIT_SEF] = 1'b1;
            set_ev[frame_sync_pkg::BIT_SEF] = 1'b1;
            q_nxt.sef_frames = 6'h00;
            q_nxt.ok_cnt = 4'h0;
            q_nxt.err_cnt = 4'h0;
          end
        end
        frame_sync_pkg::ST_SEF1_LOF0: begin
          q_nxt.sef_frames = q_r.sef_frames + 6'h01;
          if (ok_n >= frame_sync_pkg::CLEAN_CLEAR) begin
            q_nxt.state = frame_sync_pkg::ST_IN_FRAME;
            q_nxt.status[frame_sync_pkg::BIT_SEF] = 1'b0;
            set_ev[frame_sync_pkg::BIT_SEF] = 1'b1;
            q_nxt.ok_cnt = 4'h0;
            q_nxt.err_cnt = 4'h0;
          end else if (q_r.sef_frames + 6'h01 >= frame_sync_pkg::LOF_FRAMES) begin
            q_nxt.state = frame_sync_pkg::ST_SEF1_LOF1;
            q_nxt.status[frame_sync_pkg::BIT_LOF] = 1'b1;
            set_ev[frame_sync_pkg::BIT_LOF] = 1'b1;
            q_nxt.ok_cnt = 4'h0;
            q_nxt.err_cnt = 4'h0;
          end
          // Otherwise SEF stays declared
        end
        default: begin
          q_nxt.state = frame_sync_pkg::ST_SEF1_LOF1;
        end
      endcase
    end

    // AXI4-Lite write side
    aw_go = awvalid_i && !q_r.aw_have && !q_r.bvalid;
    if (aw_go) begin
      q_nxt.aw_addr = awaddr_i;
      q_nxt.aw_have = 1'b1;
    end
    if (wvalid_i && !q_r.w_have && !q_r.bvalid) begin
      q_nxt.w_data = wdata_i;
      q_nxt.w_strb = wstrb_i;
      q_nxt.w_have = 1'b1;
    end
    wa = aw_go ? awaddr_i : q_r.aw_addr;
    wd = q_r.w_have ? q_r.w_data : wdata_i;
    ws = q_r.w_have ? q_r.w_strb : wstrb_i;
    if (q_nxt.aw_have && q_nxt.w_have) begin
      q_nxt.aw_have = 1'b0;
      q_nxt.w_have = 1'b0;
      q_nxt.bvalid = 1'b1;
      q_nxt.bresp = frame_sync_pkg::RESP_OKAY;
      if (addr_is(wa, frame_sync_pkg::INSYNC_THRESH_OFS)) begin
        if (ws[0]) begin
          q_nxt.insync = wd[3:0];
        end
      end else if (addr_is(wa, frame_sync_pkg::EVENT_MASK_OFS)) begin
        if (ws[0]) begin
          q_nxt.mask = wd[7:0];
        end
      end else if (!addr_is(wa, frame_sync_pkg::DEFECT_STATUS_OFS) &&
                   !addr_is(wa, frame_sync_pkg::EVENT_FLAGS_OFS) &&
                   !addr_is(wa, frame_sync_pkg::FRAMING_PATTERN_OFS)) begin
        q_nxt.bresp = frame_sync_pkg::RESP_SLVERR;
      end
      // Status and event bytes ignore writes
    end
    if (q_r.bvalid && bready_i) begin
      q_nxt.bvalid = 1'b0;
    end

    // AXI4-Lite read side
    ar_go = arvalid_i && !q_r.rvalid;
    if (ar_go) begin
      q_nxt.rvalid = 1'b1;
      q_nxt.rresp = frame_sync_pkg::RESP_OKAY;
      q_nxt.rdata = 32'h0000_0000;
      if (addr_is(araddr_i, frame_sync_pkg::DEFECT_STATUS_OFS)) begin
        q_nxt.rdata[7:0] = q_r.status;
      end else if (addr_is(araddr_i, frame_sync_pkg::EVENT_FLAGS_OFS)) begin
        q_nxt.rdata[7:0] = q_r.events;
        q_nxt.events = 8'h00;
      end else if (addr_is(araddr_i, frame_sync_pkg::INSYNC_THRESH_OFS)) begin
        q_nxt.rdata[3:0] = q_r.insync;
      end else if (addr_is(araddr_i, frame_sync_pkg::EVENT_MASK_OFS)) begin
        q_nxt.rdata[7:0] = q_r.mask;
      end else if (addr_is(araddr_i, frame_sync_pkg::FRAMING_PATTERN_OFS)) begin
        q_nxt.rdata[15:0] = {frame_sync_pkg::FRAMING_A1, frame_sync_pkg::FRAMING_A2};
      end else begin
        q_nxt.rresp = frame_sync_pkg::RESP_SLVERR;
      end
    end
    if (q_r.rvalid && rready_i) begin
      q_nxt.rvalid = 1'b0;
    end

    // New events win over the read that clears them
    q_nxt.events = q_nxt.events | set_ev;
    q_nxt.irq_n = ~|(q_nxt.events & q_r.mask);
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      q_r <= '0;
      q_r.state <= frame_sync_pkg::ST_SEF1_LOF1;
      q_r.status <= 8'h00 | (8'h01 << frame_sync_pkg::BIT_SEF) | (8'h01 << frame_sync_pkg::BIT_LOF);
      q_r.mask <= frame_sync_pkg::MASK_RESET;
      q_r.insync <= frame_sync_pkg::INSYNC_RESET;
      q_r.irq_n <= 1'b1;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign awready_o = !q_r.aw_have && !q_r.bvalid;
  assign wready_o = !q_r.w_have && !q_r.bvalid;
  assign bvalid_o = q_r.bvalid;
  assign bresp_o = q_r.bresp;
  assign arready_o = !q_r.rvalid;
  assign rvalid_o = q_r.rvalid;
  assign rdata_o = q_r.rdata;
  assign rresp_o = q_r.rresp;
  assign irq_n_o = q_r.irq_n;
  assign sef_o = q_r.status[frame_sync_pkg::BIT_SEF];
  assign lof_o = q_r.status[frame_sync_pkg::BIT_LOF];
endmodule

//--- rtl/frame_sync_pkg.sv
// Contract
// - Entering In-Frame clears LOF status bit 2, sets event bit 2, asserts interrupt. Entering from SEF=1/LOF=0 sets only event bit 1.
// - In-Frame keeps checking framing bytes; isolated errored frames are tolerated.
// - Four consecutive errored frames in In-Frame declare SEF, go to SEF=1/LOF=0.
// - In-Frame to SEF=1/LOF=0 sets SEF status bit 1.
// - Declaring SEF from In-Frame sets event bit 1 and asserts interrupt.
// - In SEF=1/LOF=0, two consecutive clean frames clear SEF, return to In-Frame.
// - In SEF=1/LOF=0, SEF stays asserted while errored frames keep arriving.
// - SEF held at least 3 ms declares LOF, move to SEF=1/LOF=1.
// - Defect status byte is read-only: RDI-L,S1,K1K2,SF,SD,LOF,SEF,LOS bits 7..0.
// - Event flags byte SF,SD,REI,B2,B1,LOF,SEF,LOS chg; reset upon read.
// - In SEF=1/LOF=1, two consecutive clean frames clear SEF, go SEF=0/LOF=1.
// - In SEF=0/LOF=1, programmed count of clean frames clears LOF, enters In-Frame.
// - In SEF=0/LOF=1, four consecutive errored frames declare SEF, back to SEF=1/LOF=1.
package frame_sync_pkg;
  localparam logic [15:0] DEFECT_STATUS_OFS = 16'h1107;
  localparam logic [15:0] EVENT_FLAGS_OFS = 16'h110b;
  localparam logic [15:0] INSYNC_THRESH_OFS = 16'h112b;
  localparam logic [15:0] EVENT_MASK_OFS = 16'h1110;
  localparam logic [15:0] FRAMING_PATTERN_OFS = 16'h1114;
  localparam int ADDR_W = 16;
  localparam int BIT_LOS = 0;
  localparam int BIT_SEF = 1;
  localparam int BIT_LOF = 2;
  localparam logic [3:0] ERR_DECLARE = 4'h4;
  localparam logic [3:0] CLEAN_CLEAR = 4'h2;
  localparam logic [3:0] INSYNC_RESET = 4'h8;
  localparam logic [7:0] MASK_RESET = 8'hff;
  localparam logic [7:0] FRAMING_A1 = 8'hf6;
  localparam logic [7:0] FRAMING_A2 = 8'h28;
  localparam int LOF_TIME_US = 3000;
  localparam int FRAME_TIME_US = 125;
  // Least time rounds up to whole frames
  localparam int LOF_FRAMES_INT = (LOF_TIME_US + FRAME_TIME_US - 1) / FRAME_TIME_US;
  localparam logic [5:0] LOF_FRAMES = 6'(LOF_FRAMES_INT);
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [3:0] {
    ST_SEF1_LOF1 = 4'b0001,
    ST_SEF0_LOF1 = 4'b0010,
    ST_IN_FRAME = 4'b0100,
    ST_SEF1_LOF0 = 4'b1000
  } sync_state_t;
endpackage

//--- bench/fsync_checker.sv
`timescale 1ns/1ps
module fsync_checker (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic arvalid_i,
  input wire logic arready_o,
  input wire logic awready_o,
  input wire logic wready_o,
  input wire logic bvalid_o,
  input wire logic bready_i,
  input wire logic [1:0] bresp_o,
  input wire logic rvalid_o,
  input wire logic rready_i,
  input wire logic [31:0] rdata_o,
  input wire logic sef_o,
  input wire logic lof_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  property p_bhold; bvalid_o && !bready_i |=> bvalid_o && $stable(bresp_o); endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped");
  property p_rhold; rvalid_o && !rready_i |=> rvalid_o && $stable(rdata_o); endproperty
  a_rhold: assert property (p_rhold) else $error("read data dropped");
  property p_ar_block; rvalid_o |-> !arready_o; endproperty
  a_ar_block: assert property (p_ar_block) else $error("read taken while busy");
  property p_aw_block; bvalid_o |-> !awready_o && !wready_o; endproperty
  a_aw_block: assert property (p_aw_block) else $error("write taken while busy");
  property p_ar_ans; arvalid_i && arready_o |=> rvalid_o; endproperty
  a_ar_ans: assert property (p_ar_ans) else $error("read answer late");
  property p_upper; rvalid_o |-> rdata_o[31:8] == 24'h000000; endproperty
  a_upper: assert property (p_upper) else $error("upper read bits set");
  property p_lof_clear; $fell(lof_o) |-> !sef_o; endproperty
  a_lof_clear: assert property (p_lof_clear) else $error("lof cleared with sef");
  property p_lof_decl; $rose(lof_o) |-> sef_o; endproperty
  a_lof_decl: assert property (p_lof_decl) else $error("lof declared without sef");
endmodule

//--- bench/line_model.sv
`timescale 1ns/1ps
module line_model (
  input wire logic clk_i,
  output logic frame_start_o,
  output logic byte_valid_o,
  output logic [7:0] rx_byte_o
);
  initial begin
    frame_start_o = 1'b0;
    byte_valid_o = 1'b0;
    rx_byte_o = 8'h00;
  end
  // Idle bytes flip so a stale value never passes for framing
  task automatic put(input logic fs, input logic bv, input logic [7:0] b);
    @(posedge clk_i);
    frame_start_o <= fs;
    byte_valid_o <= bv;
    rx_byte_o <= bv ? b : ~rx_byte_o;
  endtask
  task automatic frame(input logic ok);
    put(1'b1, 1'b0, 8'h00);
    put(1'b0, 1'b1, frame_sync_pkg::FRAMING_A1);
    put(1'b0, 1'b1, ok ? frame_sync_pkg::FRAMING_A2 : 8'h00);
    put(1'b0, 1'b0, 8'h00);
    repeat (3) @(posedge clk_i);
  endtask
endmodule

//--- bench/sts3_rx_frame_sync_fsm_bench.sv
`timescale 1ns/1ps
module sts3_rx_frame_sync_fsm_bench;
  localparam logic [15:0] ST = frame_sync_pkg::DEFECT_STATUS_OFS;
  localparam logic [15:0] EV = frame_sync_pkg::EVENT_FLAGS_OFS;
  localparam logic [15:0] MK = frame_sync_pkg::EVENT_MASK_OFS;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic frame_start_i, byte_valid_i;
  logic [7:0] rx_byte_i;
  logic awvalid_i = 1'b0, wvalid_i = 1'b0, bready_i = 1'b0, arvalid_i = 1'b0, rready_i = 1'b0;
  logic [15:0] awaddr_i = 16'h0000, araddr_i = 16'h0000;
  logic [31:0] wdata_i = 32'h00000000;
  logic [3:0] wstrb_i = 4'h1;
  logic awready_o, wready_o, bvalid_o, arready_o, rvalid_o, irq_n_o, sef_o, lof_o;
  logic [1:0] bresp_o, rresp_o;
  logic [31:0] rdata_o;
  int n_errors = 0, cmp_count = 0, n;
  always #12.5 clk_i = ~clk_i;
  line_model lm (.clk_i(clk_i), .frame_start_o(frame_start_i), .byte_valid_o(byte_valid_i), .rx_byte_o(rx_byte_i));
  sts3_rx_frame_sync_fsm dut (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .frame_start_i(frame_start_i),
    .byte_valid_i(byte_valid_i),
    .rx_byte_i(rx_byte_i),
    .awvalid_i(awvalid_i),
    .awready_o(awready_o),
    .awaddr_i(awaddr_i),
    .wvalid_i(wvalid_i),
    .wready_o(wready_o),
    .wdata_i(wdata_i),
    .wstrb_i(wstrb_i),
    .bvalid_o(bvalid_o),
    .bready_i(bready_i),
    .bresp_o(bresp_o),
    .arvalid_i(arvalid_i),
    .arready_o(arready_o),
    .araddr_i(araddr_i),
    .rvalid_o(rvalid_o),
    .rready_i(rready_i),
    .rdata_o(rdata_o),
    .rresp_o(rresp_o),
    .irq_n_o(irq_n_o),
    .sef_o(sef_o),
    .lof_o(lof_o)
  );
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Register offsets are word indexes; only the watchdog ends the wait in wr and rd
  task automatic wr(input logic [15:0] a, input logic [31:0] v);
    awvalid_i <= 1'b1;
    awaddr_i <= {a[13:0], 2'b00};
    wvalid_i <= 1'b1;
    wdata_i <= v;
    bready_i <= 1'b1;
    do begin
      @(posedge clk_i);
      if (awready_o) awvalid_i <= 1'b0;
      if (wready_o) wvalid_i <= 1'b0;
    end while (bvalid_o !== 1'b1);
    bready_i <= 1'b0;
    chk("bresp", 32'(frame_sync_pkg::RESP_OKAY), 32'(bresp_o));
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] e, input logic [1:0] er);
    arvalid_i <= 1'b1;
    araddr_i <= {a[13:0], 2'b00};
    rready_i <= 1'b1;
    do begin
      @(posedge clk_i);
      if (arready_o) arvalid_i <= 1'b0;
    end while (rvalid_o !== 1'b1);
    rready_i <= 1'b0;
    chk($sformatf("rresp %h", a), 32'(er), 32'(rresp_o));
    if (er == frame_sync_pkg::RESP_OKAY) chk($sformatf("reg %h", a), e, rdata_o);
    @(posedge clk_i);
  endtask
  task automatic fr(input int k, input logic ok);
    repeat (k) lm.frame(ok);
  endtask
  task automatic pins(input logic s, input logic l);
    chk("sef_o", 32'(s), 32'(sef_o));
    chk("lof_o", 32'(l), 32'(lof_o));
  endtask
  task automatic t_reset();
    rd(ST, 32'h06, 2'h0);
    rd(frame_sync_pkg::INSYNC_THRESH_OFS, 32'h08, 2'h0);
    wr(ST, 32'hff);
    rd(ST, 32'h06, 2'h0);
    rd(16'h2000, 32'h0, frame_sync_pkg::RESP_SLVERR);
    $display("reset test done");
  endtask
  task automatic t_acquire();
    wr(frame_sync_pkg::INSYNC_THRESH_OFS, 32'h3);
    fr(2, 1'b1);
    pins(1'b0, 1'b1);
    rd(EV, 32'h02, 2'h0);
    fr(2, 1'b1);
    pins(1'b0, 1'b1);
    fr(1, 1'b1);
    pins(1'b0, 1'b0);
    chk("irq_n_o", 32'h0, 32'(irq_n_o));
    rd(ST, 32'h00, 2'h0);
    rd(EV, 32'h04, 2'h0);
    rd(EV, 32'h00, 2'h0);
    chk("irq_n_o", 32'h1, 32'(irq_n_o));
    $display("acquire test done");
  endtask
  task automatic t_inframe();
    fr(3, 1'b0);
    fr(1, 1'b1);
    fr(3, 1'b0);
    pins(1'b0, 1'b0);
    fr(1, 1'b0);
    pins(1'b1, 1'b0);
    chk("irq_n_o", 32'h0, 32'(irq_n_o));
    rd(EV, 32'h02, 2'h0);
    fr(3, 1'b0);
    pins(1'b1, 1'b0);
    fr(2, 1'b1);
    pins(1'b0, 1'b0);
    rd(EV, 32'h02, 2'h0);
    $display("in-frame test done");
  endtask
  task automatic t_lof();
    fr(4, 1'b0);
    n = 0;
    while (lof_o !== 1'b1 && n < 40) begin
      lm.frame(1'b0);
      n++;
    end
    chk("frames to lof", 32'(frame_sync_pkg::LOF_FRAMES), 32'(n));
    pins(1'b1, 1'b1);
    fr(2, 1'b1);
    pins(1'b0, 1'b1);
    fr(4, 1'b0);
    pins(1'b1, 1'b1);
    rd(EV, 32'h06, 2'h0);
    $display("lof test done");
  endtask
  task automatic t_mask();
    wr(MK, 32'h00);
    fr(2, 1'b1);
    chk("irq_n_o", 32'h1, 32'(irq_n_o));
    wr(MK, 32'hff);
    repeat (2) @(posedge clk_i);
    chk("irq_n_o", 32'h0, 32'(irq_n_o));
    rd(EV, 32'h02, 2'h0);
    repeat (2) @(posedge clk_i);
    chk("irq_n_o", 32'h1, 32'(irq_n_o));
    $display("mask test done");
  endtask
  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk_i);
    arst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    t_reset();
    t_acquire();
    t_inframe();
    t_lof();
    t_mask();
    stop_test();
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    stop_test();
  end
endmodule
bind sts3_rx_frame_sync_fsm fsync_checker chk_u (
  .clk_i(clk_i),
  .arst_n_i(arst_n_i),
  .arvalid_i(arvalid_i),
  .arready_o(arready_o),
  .awready_o(awready_o),
  .wready_o(wready_o),
  .bvalid_o(bvalid_o),
  .bready_i(bready_i),
  .bresp_o(bresp_o),
  .rvalid_o(rvalid_o),
  .rready_i(rready_i),
  .rdata_o(rdata_o),
  .sef_o(sef_o),
  .lof_o(lof_o)
);
